// ---- core/pll_ports_pkg.sv ----
/*
  Constants, mode codes and limits shared by the loop model and its output dividers.
  Assumes one 250 MHz clock and synchronous reference inputs sampled on it.
*/
// Operation
// R1 - Swap request high starts a switch between the two reference inputs.
// R2 - Loop reset high resets the loop and resynchronizes every divider output.
// R3 - Detector outputs steer the oscillator only while the gate enable is high.
// R4 - Five output dividers; only the first also feeds the external clock pin.
// R5 - Two failed bits, one per reference: 0 toggling, 1 stopped.
// R6 - Active-high lock flag from the lock detector goes to core logic.
// R7 - Selected reference indicator: low for primary, high for secondary.
// R8 - One prescaler and one feedback multiplier, each 1 through 512.
// R9 - Prescaler divides frequency only; no high or low time applied.
// R10 - Output divider 1-512 at 50% duty, 1-256 for other duty.
// R11 - Output divide ratio equals high count plus low count.
// R12 - Oscillator = input times multiplier over prescaler; outputs divide it further.
// R13 - Each output clock has its own divider fed from the shared oscillator.
// R14 - Other party feeds references only from clock pins, loops or pin-driven nets.
// R15 - Up to four feedback modes, each keeping multiply, divide and duty control.
// R16 - During loop reset dividers held, outputs low, lock low; relock afterwards.
// R17 - Selected input low about two periods sets its failed bit and switches.
// R18 - Gate disabled: oscillator holds control, keeps running; lock untrusted.
// R19 - Oscillator modelled as accumulator tracking multiplier and prescaler; lock after settling.
package pll_ports_pkg;
  localparam int NUM_OUTPUTS = 5;
  localparam int CNT_W = 9;
  localparam int TOTAL_W = 10;
  localparam logic [TOTAL_W-1:0] MAX_TOTAL_EVEN = 10'h0200;
  localparam logic [TOTAL_W-1:0] MAX_TOTAL_ODD = 10'h0100;
  localparam int NCO_W = 32;
  localparam logic [NCO_W-1:0] NCO_NOMINAL = 32'h1000_0000;
  localparam logic [NCO_W-1:0] NCO_STEP = 32'h0001_0000;
  localparam logic [NCO_W-1:0] NCO_MAX = 32'h8000_0000;
  localparam int SINCE_W = 16;
  localparam logic [SINCE_W-1:0] SINCE_MAX = 16'hFFFF;
  localparam int MISS_PERIODS = 2;
  localparam int LOCK_W = 16;
  localparam logic [LOCK_W-1:0] LOCK_SETTLE = 16'h0010;

  typedef enum logic [3:0] {
    MODE_SOURCE_SYNC = 4'b0001,
    MODE_NO_COMP = 4'b0010,
    MODE_NORMAL = 4'b0100,
    MODE_ZERO_DELAY = 4'b1000
  } fb_mode_t;
endpackage

// ---- core/output_divider.sv ----
/*
  One post-scale divider: counts oscillator ticks through a high then a low phase.
  Assumes the tick is a one-cycle pulse and counts are stable while running.
*/
`timescale 1ns/1ps
module output_divider #(
  parameter int W = pll_ports_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hold,
  input wire logic tick,
  input wire logic [W-1:0] high_cnt,
  input wire logic [W-1:0] low_cnt,
  output logic clk_d,
  output logic clk_q,
  output logic cfg_bad
);
  // ==========================================================
  // Configuration check
  logic [W:0] total;
  logic unequal;
  assign total = {1'b0, high_cnt} + {1'b0, low_cnt}; // R11
  assign unequal = (high_cnt != low_cnt);
  assign cfg_bad = (total == '0) || (total > pll_ports_pkg::MAX_TOTAL_EVEN) ||
                   (unequal && (total > pll_ports_pkg::MAX_TOTAL_ODD)); // R10

  // ==========================================================
  // Phase counting
  logic phase_q, phase_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] limit;
  logic [W-1:0] other;
  logic last;
  logic stop;
  assign limit = phase_q ? high_cnt : low_cnt;
  assign other = phase_q ? low_cnt : high_cnt;
  assign last = ({1'b0, cnt_q} + 1'b1) >= {1'b0, limit};
  assign stop = hold || cfg_bad;
  assign cnt_d = stop ? '0 : (tick ? (last ? '0 : cnt_q + 1'b1) : cnt_q);
  assign phase_d = stop ? (high_cnt != '0) :
                   ((tick && last && other != '0) ? ~phase_q : phase_q);
  // Ratio 1 passes the oscillator tick straight through
  assign clk_d = stop ? 1'b0 : ((total == 1) ? tick : phase_d); // R16

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= 1'b1;
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end
endmodule // output_divider

// ---- core/pll_ports_and_dividers.sv ----
/*
  Digital model of the loop: reference monitor and switchover, prescaler,
  feedback multiplier, accumulator oscillator, lock detector, five output dividers.
  Assumes all inputs are synchronous to MCLK; reference edges are far slower than MCLK.
*/
`timescale 1ns/1ps
module pll_ports_and_dividers #(
  parameter int N_OUT = pll_ports_pkg::NUM_OUTPUTS,
  parameter int W = pll_ports_pkg::CNT_W,
  parameter logic [pll_ports_pkg::LOCK_W-1:0] LOCK_COUNT = pll_ports_pkg::LOCK_SETTLE
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic REF_CLOCK_PRIMARY,
  input wire logic REF_CLOCK_SECONDARY,
  input wire logic SWAP_REQ,
  input wire logic LOOP_RESET,
  input wire logic DETECT_GATE_EN,
  input wire logic [3:0] FB_MODE,
  input wire logic EXT_OUT_EN,
  input wire logic [W-1:0] PRESCALE,
  input wire logic [W-1:0] MULTIPLY,
  input wire logic [N_OUT*W-1:0] DIV_HIGH,
  input wire logic [N_OUT*W-1:0] DIV_LOW,
  output logic [N_OUT-1:0] CLK_OUT,
  output logic EXT_CLK_OUT,
  output logic [1:0] REF_FAILED,
  output logic REF_SELECTED,
  output logic LOCKED,
  output logic [N_OUT-1:0] DIV_CFG_ERR,
  output logic [3:0] FB_MODE_ACTIVE
);
  // ==========================================================
  // Loop reset
  logic loop_rst;
  assign loop_rst = LOOP_RESET; // R2

  // ==========================================================
  // Reference monitors, one per input
  logic [1:0] ref_in;
  logic [1:0] ref_prev_q;
  logic [1:0] ref_rise;
  logic [1:0] bad_q;
  assign ref_in = {REF_CLOCK_SECONDARY, REF_CLOCK_PRIMARY};
  assign ref_rise = ref_in & ~ref_prev_q;

  for (genvar i = 0; i < 2; i++) begin : g_mon
    logic [pll_ports_pkg::SINCE_W-1:0] since_q;
    logic [pll_ports_pkg::SINCE_W-1:0] period_q;
    logic [pll_ports_pkg::SINCE_W:0] miss_lim;
    logic stopped;
    logic fail_q;
    // Product is cut back to the counter width plus one carry bit
    assign miss_lim = (pll_ports_pkg::SINCE_W + 1)'({1'b0, period_q} * pll_ports_pkg::MISS_PERIODS);
    assign bad_q[i] = fail_q;
    assign stopped = (since_q == pll_ports_pkg::SINCE_MAX) ||
                     ((period_q != '0) && ({1'b0, since_q} >= miss_lim)); // R17
    always_ff @(posedge MCLK) begin
      if (!RST_B) begin
        since_q <= '0;
        period_q <= '0;
        fail_q <= 1'b0;
      end else begin
        since_q <= ref_rise[i] ? '0 :
                   (since_q == pll_ports_pkg::SINCE_MAX ? since_q : since_q + 1'b1);
        if (ref_rise[i])
          period_q <= since_q + 1'b1;
        fail_q <= ref_rise[i] ? 1'b0 : stopped; // R5
      end
    end
  end

  // ==========================================================
  // Switchover
  logic sel_q;
  logic swap_prev_q;
  logic swap_rise;
  logic auto_sw;
  logic do_switch;
  assign swap_rise = SWAP_REQ && !swap_prev_q; // R1
  assign auto_sw = bad_q[sel_q] && !bad_q[~sel_q]; // R17
  assign do_switch = swap_rise || auto_sw;

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      ref_prev_q <= '0;
      swap_prev_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_in;
      swap_prev_q <= SWAP_REQ;
      if (do_switch)
        sel_q <= ~sel_q; // R7
    end
  end

  // ==========================================================
  // Prescaler and feedback multiplier (0 encodes 512)
  logic restart;
  logic [W-1:0] n_cnt_q;
  logic [W-1:0] m_cnt_q;
  logic [W-1:0] n_last;
  logic [W-1:0] m_last;
  logic ref_evt;
  logic fb_evt;
  logic vco_tick;
  assign restart = loop_rst || do_switch;
  assign n_last = PRESCALE - 1'b1;
  assign m_last = MULTIPLY - 1'b1;
  // Prescaler counts edges only, so duty never enters it
  assign ref_evt = ref_rise[sel_q] && (n_cnt_q == n_last); // R9
  assign fb_evt = vco_tick && (m_cnt_q == m_last); // R8

  always_ff @(posedge MCLK) begin
    if (!RST_B || restart) begin
      n_cnt_q <= '0;
      m_cnt_q <= '0;
    end else begin
      if (ref_rise[sel_q])
        n_cnt_q <= ref_evt ? '0 : n_cnt_q + 1'b1; // R8
      if (vco_tick)
        m_cnt_q <= fb_evt ? '0 : m_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Oscillator and detector
  logic [pll_ports_pkg::NCO_W-1:0] acc_q;
  logic [pll_ports_pkg::NCO_W-1:0] ctrl_q;
  logic [pll_ports_pkg::NCO_W:0] acc_sum;
  logic [1:0] fb_seen_q;
  logic [1:0] fb_seen_now;
  logic speed_up;
  logic slow_down;
  logic in_step;
  logic steer;
  assign acc_sum = {1'b0, acc_q} + {1'b0, ctrl_q};
  assign vco_tick = acc_sum[pll_ports_pkg::NCO_W] && !loop_rst; // R19
  assign fb_seen_now = (fb_evt && fb_seen_q != 2'h2) ? fb_seen_q + 1'b1 : fb_seen_q;
  assign steer = ref_evt && DETECT_GATE_EN; // R3
  assign speed_up = steer && (fb_seen_now == 2'h0) && (ctrl_q < pll_ports_pkg::NCO_MAX);
  assign slow_down = steer && (fb_seen_now == 2'h2) && (ctrl_q > pll_ports_pkg::NCO_STEP);
  assign in_step = steer && (fb_seen_now == 2'h1);

  always_ff @(posedge MCLK) begin
    if (!RST_B || loop_rst) begin
      acc_q <= '0;
      ctrl_q <= pll_ports_pkg::NCO_NOMINAL; // R16
      fb_seen_q <= '0;
    end else begin
      // Keeps running on held control while the gate is low
      acc_q <= acc_sum[pll_ports_pkg::NCO_W-1:0]; // R18
      fb_seen_q <= (ref_evt || do_switch) ? 2'h0 : fb_seen_now;
      if (speed_up)
        ctrl_q <= ctrl_q + pll_ports_pkg::NCO_STEP; // R12
      else if (slow_down)
        ctrl_q <= ctrl_q - pll_ports_pkg::NCO_STEP;
    end
  end

  // ==========================================================
  // Lock detector
  logic [pll_ports_pkg::LOCK_W-1:0] good_q;
  logic lock_q;
  always_ff @(posedge MCLK) begin
    if (!RST_B || restart || bad_q[sel_q]) begin
      good_q <= '0;
      lock_q <= 1'b0; // R16
    end else if (in_step) begin
      if (good_q != LOCK_COUNT)
        good_q <= good_q + 1'b1;
      lock_q <= (good_q + 1'b1) >= LOCK_COUNT; // R6
    end else if (speed_up || slow_down) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end
  end

  // ==========================================================
  // Output dividers
  logic [N_OUT-1:0] div_next;
  logic [N_OUT-1:0] div_bad;
  for (genvar k = 0; k < N_OUT; k++) begin : g_div
    output_divider #(.W(W)) u_div ( // R13
      .clk(MCLK),
      .rst_b(RST_B),
      .hold(loop_rst),
      .tick(vco_tick),
      .high_cnt(DIV_HIGH[k*W +: W]),
      .low_cnt(DIV_LOW[k*W +: W]),
      .clk_d(div_next[k]),
      .clk_q(),
      .cfg_bad(div_bad[k])
    );
  end

  // ==========================================================
  // Status and clock outputs
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      CLK_OUT <= '0;
      EXT_CLK_OUT <= 1'b0;
      REF_FAILED <= '0;
      REF_SELECTED <= 1'b0;
      LOCKED <= 1'b0;
      DIV_CFG_ERR <= '0;
      FB_MODE_ACTIVE <= pll_ports_pkg::MODE_NORMAL;
    end else begin
      CLK_OUT <= div_next;
      EXT_CLK_OUT <= EXT_OUT_EN && div_next[0]; // R4
      REF_FAILED <= bad_q; // R5
      REF_SELECTED <= sel_q; // R7
      LOCKED <= lock_q && !loop_rst; // R6
      DIV_CFG_ERR <= div_bad;
      if (loop_rst && ($onehot(FB_MODE)))
        FB_MODE_ACTIVE <= FB_MODE; // R15
    end
  end
endmodule // pll_ports_and_dividers

// ---- sim/pll_ref_source.sv ----
/* Far-side model: two reference clocks, period 2*HALF MCLK cycles.
   A stopped reference sits low; assumes the bench's MCLK and RST_B. */
`timescale 1ns/1ps
module ref_source #(
  parameter int HALF = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] stop,
  output logic ref0,
  output logic ref1
);
  int cnt;
  logic ph;
  always_ff @(posedge clk) begin
    if (!rst_b || cnt == HALF - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    if (!rst_b) begin
      ph <= 1'b0;
    end else if (cnt == HALF - 1) begin
      ph <= ~ph;
    end
  end
  // Clean periodic source, as from a dedicated clock pin
  assign ref0 = ph & ~stop[0];
  assign ref1 = ph & ~stop[1];
endmodule // ref_source

// ---- sim/pll_ports_sva.sv ----
/* Port checker for the loop model.
   Assumes one MCLK domain with synchronous RST_B. */
`timescale 1ns/1ps
module pll_ports_sva #(
  parameter int N_OUT = 5,
  parameter int W = 9
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SWAP_REQ,
  input wire logic LOOP_RESET,
  input wire logic EXT_OUT_EN,
  input wire logic [3:0] FB_MODE,
  input wire logic [N_OUT*W-1:0] DIV_HIGH,
  input wire logic [N_OUT*W-1:0] DIV_LOW,
  input wire logic [N_OUT-1:0] CLK_OUT,
  input wire logic EXT_CLK_OUT,
  input wire logic [1:0] REF_FAILED,
  input wire logic REF_SELECTED,
  input wire logic LOCKED,
  input wire logic [N_OUT-1:0] DIV_CFG_ERR,
  input wire logic [3:0] FB_MODE_ACTIVE
);
  logic [W-1:0] h4;
  logic [W-1:0] l4;
  logic [W:0] t4;
  logic bad4;
  assign h4 = DIV_HIGH[N_OUT*W-1 -: W];
  assign l4 = DIV_LOW[N_OUT*W-1 -: W];
  assign t4 = {1'b0, h4} + {1'b0, l4};
  assign bad4 = t4 == 10'h000 || t4 > 10'h200 || (h4 != l4 && t4 > 10'h100);
  // =======
  // Properties
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_lr2;
    LOOP_RESET[*2];
  endsequence
  sequence s_still;
    $stable({DIV_HIGH, DIV_LOW})[*2];
  endsequence
  property p_loop_clear;
    s_lr2 |=> CLK_OUT == '0 && !LOCKED;
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("loop reset kept outputs");
  property p_swap;
    $rose(SWAP_REQ) |-> ##2 REF_SELECTED != $past(REF_SELECTED, 2) && !LOCKED;
  endproperty
  a_swap: assert property (p_swap) else $error("swap not taken");
  property p_auto_switch;
    $rose(REF_FAILED[0]) && !REF_FAILED[1] && !REF_SELECTED |=> REF_SELECTED;
  endproperty
  a_auto_switch: assert property (p_auto_switch) else $error("no auto switch");
  property p_ext_copy;
    EXT_CLK_OUT == (CLK_OUT[0] && $past(EXT_OUT_EN));
  endproperty
  a_ext_copy: assert property (p_ext_copy) else $error("ext pin not output 0");
  property p_fail_unlock;
    REF_FAILED[REF_SELECTED] |=> !LOCKED;
  endproperty
  a_fail_unlock: assert property (p_fail_unlock) else $error("lock kept on failed input");
  property p_cfg_hold;
    (DIV_CFG_ERR & $past(DIV_CFG_ERR) & CLK_OUT) == '0;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("bad divider toggles");
  property p_cfg_err;
    s_still |-> DIV_CFG_ERR[N_OUT-1] == bad4;
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("divider range flag wrong");
  property p_mode_latch;
    LOOP_RESET && $onehot(FB_MODE) |=> FB_MODE_ACTIVE == $past(FB_MODE);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");
  property p_mode_keep;
    !LOOP_RESET |=> $stable(FB_MODE_ACTIVE);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode changed");
endmodule // pll_ports_sva
bind pll_ports_and_dividers pll_ports_sva #(.N_OUT(N_OUT), .W(W)) u_sva (
  .MCLK(MCLK), .RST_B(RST_B), .SWAP_REQ(SWAP_REQ), .LOOP_RESET(LOOP_RESET),
  .EXT_OUT_EN(EXT_OUT_EN),
  .FB_MODE(FB_MODE), .DIV_HIGH(DIV_HIGH), .DIV_LOW(DIV_LOW), .CLK_OUT(CLK_OUT),
  .EXT_CLK_OUT(EXT_CLK_OUT), .REF_FAILED(REF_FAILED), .REF_SELECTED(REF_SELECTED),
  .LOCKED(LOCKED), .DIV_CFG_ERR(DIV_CFG_ERR), .FB_MODE_ACTIVE(FB_MODE_ACTIVE));

// ---- sim/test_pll_ports_and_dividers.sv ----
/* Self-checking bench for the loop model.
   Assumes ref_source and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module test_pll_ports_and_dividers;
  localparam int REF_PER = 64;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic SWAP_REQ = 1'b0;
  logic LOOP_RESET = 1'b0;
  logic DETECT_GATE_EN = 1'b1;
  logic [3:0] FB_MODE = 4'h4;
  logic EXT_OUT_EN = 1'b1;
  logic [8:0] PRESCALE = 9'h001;
  logic [8:0] MULTIPLY = 9'h004;
  logic [44:0] DIV_HIGH = {9'h004, 9'h003, 9'h001, 9'h002, 9'h001};
  logic [44:0] DIV_LOW = {9'h004, 9'h003, 9'h002, 9'h001, 9'h001};
  logic [1:0] stop = 2'b00;
  logic ref0, ref1, EXT_CLK_OUT, REF_SELECTED, LOCKED, e;
  logic sel_p = 1'b0;
  logic [4:0] CLK_OUT, DIV_CFG_ERR;
  logic [1:0] REF_FAILED;
  logic [3:0] FB_MODE_ACTIVE;
  logic [8:0] h, l;
  logic [9:0] t;
  logic [31:0] seed = 32'haf6b_adf4;
  logic [31:0] sel_q[$];
  int bad_count = 0;
  int n_tests = 0;
  int i, k;

  initial begin
    forever #2 MCLK = ~MCLK;
  end

  ref_source u_ref (.clk(MCLK), .rst_b(RST_B), .stop(stop), .ref0(ref0), .ref1(ref1));
  pll_ports_and_dividers #(.LOCK_COUNT(16'h0004)) u_dut (.MCLK(MCLK), .RST_B(RST_B),
    .REF_CLOCK_PRIMARY(ref0), .REF_CLOCK_SECONDARY(ref1), .SWAP_REQ(SWAP_REQ),
    .LOOP_RESET(LOOP_RESET), .DETECT_GATE_EN(DETECT_GATE_EN), .FB_MODE(FB_MODE),
    .EXT_OUT_EN(EXT_OUT_EN), .PRESCALE(PRESCALE), .MULTIPLY(MULTIPLY),
    .DIV_HIGH(DIV_HIGH), .DIV_LOW(DIV_LOW), .CLK_OUT(CLK_OUT), .EXT_CLK_OUT(EXT_CLK_OUT),
    .REF_FAILED(REF_FAILED), .REF_SELECTED(REF_SELECTED), .LOCKED(LOCKED),
    .DIV_CFG_ERR(DIV_CFG_ERR), .FB_MODE_ACTIVE(FB_MODE_ACTIVE));

  // =======
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic lapse(inout int n);
    @(posedge MCLK);
    #1;
    n++;
    if (n > 5000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Average of four periods of one output, in MCLK cycles
  task automatic per(input int k, input int ex);
    int n, c, r;
    logic p;
    n = 0;
    c = 0;
    r = 0;
    p = 1'b1;
    while (r < 5) begin
      lapse(n);
      if (r > 0) c++;
      if (CLK_OUT[k] === 1'b1 && !p) r++;
      p = CLK_OUT[k];
    end
    chk(32'(c / 4 + 2 >= ex && c / 4 <= ex + 2), 32'h0000_0001);
  endtask

  // Selection changes are compared with the oldest noted expectation
  always @(posedge MCLK) begin
    #1;
    if (RST_B === 1'b1 && REF_SELECTED !== sel_p) begin
      chk(REF_SELECTED, sel_q.size() > 0 ? sel_q.pop_front() : 32'h0000_0002);
    end
    sel_p = REF_SELECTED;
  end

  // =======
  // Scenarios
  initial begin
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    #1;
    chk({CLK_OUT, LOCKED, REF_FAILED, REF_SELECTED, FB_MODE_ACTIVE}, 32'h0000_0004);
    for (k = 0; k < 4; k++) begin
      @(posedge MCLK);
      LOOP_RESET <= 1'b1;
      FB_MODE <= 4'h1 << k;
      repeat (4) @(posedge MCLK);
      #1;
      chk({CLK_OUT, LOCKED}, 32'h0000_0000);
      @(posedge MCLK);
      LOOP_RESET <= 1'b0;
      repeat (2) @(posedge MCLK);
      #1;
      chk(FB_MODE_ACTIVE, 4'h1 << k);
    end
    i = 0;
    while (LOCKED !== 1'b1) lapse(i);
    for (k = 0; k < 5; k++) begin
      per(k, REF_PER * PRESCALE / MULTIPLY * (DIV_HIGH[9*k +: 9] + DIV_LOW[9*k +: 9]));
    end
    for (i = 0; i < 12; i++) begin
      h = i == 0 ? 9'h100 : i == 1 ? 9'h0ff : i == 2 ? 9'h000 : 9'(xs());
      l = i == 2 ? 9'h000 : i < 2 ? 9'h100 : 9'(xs());
      t = h + l;
      @(posedge MCLK);
      DIV_HIGH[44:36] <= h;
      DIV_LOW[44:36] <= l;
      repeat (3) @(posedge MCLK);
      #1;
      chk(DIV_CFG_ERR[4], t == 10'h000 || t > 10'h200 || (h != l && t > 10'h100));
    end
    @(posedge MCLK);
    EXT_OUT_EN <= 1'b0;
    repeat (2) @(posedge MCLK);
    e = 1'b0;
    repeat (64) begin
      @(posedge MCLK);
      #1;
      e = e | EXT_CLK_OUT;
    end
    chk(e, 1'b0);
    sel_q.push_back(32'h0000_0001);
    sel_q.push_back(32'h0000_0000);
    for (k = 0; k < 4; k++) begin
      @(posedge MCLK);
      SWAP_REQ <= ~SWAP_REQ;
    end
    i = 0;
    while (LOCKED !== 1'b1) lapse(i);
    sel_q.push_back(32'h0000_0001);
    @(posedge MCLK);
    stop <= 2'b01;
    i = 0;
    while (REF_FAILED[0] !== 1'b1) lapse(i);
    repeat (2) @(posedge MCLK);
    #1;
    chk(REF_FAILED, 2'b01);
    @(posedge MCLK);
    stop <= 2'b00;
    i = 0;
    while (REF_FAILED !== 2'b00) lapse(i);
    @(posedge MCLK);
    DETECT_GATE_EN <= 1'b0;
    stop <= 2'b01;
    per(0, REF_PER * PRESCALE / MULTIPLY * 2);
    // Restarted input measured a long gap, so the miss limit is long too
    i = 0;
    while (REF_FAILED[0] !== 1'b1) lapse(i);
    chk({REF_FAILED, REF_SELECTED}, 3'b011);
    chk(sel_q.size(), 32'h0000_0000);
    tally_and_finish();
  end
endmodule // test_pll_ports_and_dividers
